// File: verilog/lsl_pkg.sv
package lsl_pkg;

    // ---------------------------------------------------------------
    // register map and bus
    // ---------------------------------------------------------------
    localparam int          ADDR_W           = 32;
    localparam int          DATA_W           = 16;
    localparam logic [31:0] RX_TX_DATA_ADDR  = 32'h5000_1000;
    localparam logic [31:0] LINE_STATUS_ADDR = 32'h5000_1014;
    localparam logic [31:0] LINE_CFG_ADDR    = 32'h5000_1040;
    localparam logic [31:0] INT_STATUS_ADDR  = 32'h5000_1044;
    localparam logic [31:0] INT_MASK_ADDR    = 32'h5000_1048;

    // ---------------------------------------------------------------
    // line_status fields
    // ---------------------------------------------------------------
    localparam int LSR_DR   = 0;
    localparam int LSR_OE   = 1;
    localparam int LSR_PE   = 2;
    localparam int LSR_FE   = 3;
    localparam int LSR_BRK  = 4;
    localparam int LSR_THRE = 5;
    localparam int LSR_TEMT = 6;
    localparam int LSR_RFE  = 7;
    localparam logic [15:0] LSR_RESET = 16'h0060;

    // ---------------------------------------------------------------
    // line configuration fields
    // ---------------------------------------------------------------
    localparam int CFG_FIFO_EN   = 0;
    localparam int CFG_PAR_EN    = 1;
    localparam int CFG_EVEN_PAR  = 2;
    localparam int CFG_IR_MODE   = 3;
    localparam int CFG_THRE_MODE = 4;
    localparam int CFG_LEN_LO    = 5;
    localparam int CFG_TXTH_LO   = 7;
    localparam logic [15:0] CFG_RESET = 16'h0060;

    // ---------------------------------------------------------------
    // interrupt status / mask fields
    // ---------------------------------------------------------------
    localparam int INT_RX   = 0;
    localparam int INT_ERR  = 1;
    localparam int INT_THRE = 2;
    localparam int INT_W    = 3;

    // ---------------------------------------------------------------
    // fifo and timing
    // ---------------------------------------------------------------
    localparam int         FIFO_DEPTH = 16;
    localparam logic [4:0] FIFO_FULL  = 5'h10;
    localparam logic [3:0] OVS_MID    = 4'h7;
    localparam logic [3:0] OVS_LAST   = 4'hF;
    localparam logic [3:0] IR_HOLD    = 4'hF;
    localparam logic [7:0] LOW_MAX    = 8'hFF;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        LSL_RX_IDLE   = 3'b000,
        LSL_RX_START  = 3'b001,
        LSL_RX_DATA   = 3'b010,
        LSL_RX_PARITY = 3'b011,
        LSL_RX_STOP   = 3'b100,
        LSL_RX_BREAK  = 3'b101,
        LSL_RX_WAITHI = 3'b110
    } lsl_rx_state_t;

    typedef enum logic [0:0] {
        LSL_TX_IDLE  = 1'b0,
        LSL_TX_SHIFT = 1'b1
    } lsl_tx_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } lsl_bus_req_t;

    typedef struct packed {
        logic       brk;
        logic       fe;
        logic       pe;
        logic [7:0] data;
    } lsl_rx_entry_t;

endpackage

// File: verilog/lsl_line_status.sv
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
// Contract
// - fifo error flag set for errored held char
// - fifo error clears only when none behind head
// - tx empty when shifter and fifo empty
// - holding-empty set on move to shifter
// - thre mode plus fifo: bit shows full
// - break when line low beyond char time
// - ir break when pulsed low beyond char
// - exactly one zero char per break
// - break shown at fifo head, else immediately
// - status read clears break, fe, pe, overrun
// - framing error on bad stop bit
// - resync: bad stop becomes next start
// - break also sets framing and parity error
// - parity error only when parity enabled, or on a break
// - non-fifo overrun overwrites buffer register
// - fifo overrun keeps fifo, drops new char
// - data ready while any char held
module lsl_line_status
    import lsl_pkg::*;
(
    input  wire logic         i_mclk,
    input  wire logic         i_reset_n,
    input  wire lsl_bus_req_t i_bus,
    output logic [DATA_W-1:0] o_rdata,
    input  wire logic         i_sample_tick,
    input  wire logic         i_rx_serial,
    input  wire logic         i_ir_serial,
    output logic              o_tx_serial,
    output logic              o_irq
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic                                rx_s1;
        logic                                rx_s2;
        logic                                ir_s1;
        logic                                ir_s2;
        logic [3:0]                          ir_hold;
        lsl_rx_state_t                       rx_st;
        logic [3:0]                          rx_ovs;
        logic [2:0]                          rx_bit;
        logic [7:0]                          rx_shift;
        logic                                rx_par;
        logic [7:0]                          low_cnt;
        lsl_rx_entry_t [FIFO_DEPTH-1:0]      rx_mem;
        logic [3:0]                          rx_rd;
        logic [4:0]                          rx_cnt;
        logic [FIFO_DEPTH-1:0][7:0]          tx_mem;
        logic [3:0]                          tx_rd;
        logic [4:0]                          tx_cnt;
        lsl_tx_state_t                       tx_st;
        logic [3:0]                          tx_ovs;
        logic [11:0]                         tx_shift;
        logic [3:0]                          tx_left;
        logic                                oe;
        logic                                pe;
        logic                                fe;
        logic                                brk;
        logic                                rfe;
        logic [DATA_W-1:0]                   cfg;
        logic [INT_W-1:0]                    int_st;
        logic [INT_W-1:0]                    int_mask;
        logic                                irq;
        logic [DATA_W-1:0]                   rdata;
    } lsl_state_t;

    lsl_state_t    s;
    lsl_state_t    next_s;

    logic          fifo_en;
    logic          parity_enable_bit;
    logic          even_par;
    logic          ir_on;
    logic          thre_fifo;
    logic [1:0]    len;
    logic [3:0]    nbits;
    logic [7:0]    char_ticks;
    logic          rx_lvl;
    logic          tick;
    logic [4:0]    rx_cap;
    logic [4:0]    thre_level;

    assign fifo_en    = s.cfg[CFG_FIFO_EN];
    assign parity_enable_bit        = s.cfg[CFG_PAR_EN];
    assign even_par   = s.cfg[CFG_EVEN_PAR];
    assign ir_on      = s.cfg[CFG_IR_MODE];
    assign thre_fifo  = s.cfg[CFG_THRE_MODE] & fifo_en;
    assign len        = s.cfg[CFG_LEN_LO +: 2];
    assign nbits      = 4'(len) + 4'h5;
    // start + data + parity + stop, sixteen sample ticks each
    assign char_ticks = {(4'h2 + nbits + {3'h0, parity_enable_bit}), 4'h0};
    assign tick       = i_sample_tick;
    assign rx_cap     = fifo_en ? FIFO_FULL : 5'h01;

    // ir pulses are short; stretch each one over a bit time so that
    // steady pulsing reads as a steady low
    assign rx_lvl = ir_on ? (s.ir_s2 & (s.ir_hold == 4'h0)) : s.rx_s2;

    always_comb begin
        unique case (s.cfg[CFG_TXTH_LO +: 2])
            2'b00: thre_level = 5'h00;
            2'b01: thre_level = 5'h02;
            2'b10: thre_level = 5'h04;
            2'b11: thre_level = 5'h08;
        endcase
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    logic          push;
    lsl_rx_entry_t push_ent;
    logic          head_changed;
    logic          err_behind;
    logic          rx_write;
    logic          tx_pop;
    logic          tx_write;
    logic [3:0]    idx;
    logic [7:0]    rx_char;
    logic          rx_perr;
    logic [7:0]    tx_data;
    logic          tx_par;
    logic [15:0]   lsr;
    logic          lsr_rd;

    always_comb begin
        next_s       = s;
        push         = 1'b0;
        push_ent     = '0;
        head_changed = 1'b0;
        err_behind   = 1'b0;
        rx_write     = 1'b0;
        tx_pop       = 1'b0;
        idx          = 4'h0;
        tx_data      = 8'h00;
        tx_par       = 1'b0;
        lsr_rd       = i_bus.rd && (i_bus.addr == LINE_STATUS_ADDR);
        tx_write     = i_bus.wr && (i_bus.addr == RX_TX_DATA_ADDR);
        rx_char      = s.rx_shift >> (2'h3 - len);
        rx_perr      = parity_enable_bit & ((^rx_char) ^ s.rx_par ^ ~even_par);

        // -----------------------------------------------------------
        // pin synchronisers and ir stretch
        // -----------------------------------------------------------
        next_s.rx_s1 = i_rx_serial;
        next_s.rx_s2 = s.rx_s1;
        next_s.ir_s1 = i_ir_serial;
        next_s.ir_s2 = s.ir_s1;
        if (tick) begin
            if (!s.ir_s2) begin
                next_s.ir_hold = IR_HOLD;
            end else if (s.ir_hold != 4'h0) begin
                next_s.ir_hold = s.ir_hold - 4'h1;
            end
            if (rx_lvl) begin
                next_s.low_cnt = 8'h00;
            end else if (s.low_cnt != LOW_MAX) begin
                next_s.low_cnt = s.low_cnt + 8'h01;
            end
        end

        // -----------------------------------------------------------
        // receiver
        // -----------------------------------------------------------
        if (tick) begin
            next_s.rx_ovs = s.rx_ovs + 4'h1;
            unique case (s.rx_st)
                LSL_RX_IDLE: begin
                    next_s.rx_ovs = 4'h0;
                    if (!rx_lvl) begin
                        next_s.rx_st = LSL_RX_START;
                    end
                end
                LSL_RX_START: begin
                    if (s.rx_ovs == OVS_MID) begin
                        next_s.rx_ovs   = 4'h0;
                        next_s.rx_bit   = 3'h0;
                        next_s.rx_shift = 8'h00;
                        next_s.rx_st    = rx_lvl ? LSL_RX_IDLE : LSL_RX_DATA;
                    end
                end
                LSL_RX_DATA: begin
                    if (s.rx_ovs == OVS_LAST) begin
                        next_s.rx_shift = {rx_lvl, s.rx_shift[7:1]};
                        next_s.rx_bit   = s.rx_bit + 3'h1;
                        next_s.rx_par   = 1'b0;
                        if (s.rx_bit == {1'b1, len}) begin
                            next_s.rx_st = parity_enable_bit ? LSL_RX_PARITY : LSL_RX_STOP;
                        end
                    end
                end
                LSL_RX_PARITY: begin
                    if (s.rx_ovs == OVS_LAST) begin
                        next_s.rx_par = rx_lvl;
                        next_s.rx_st  = LSL_RX_STOP;
                    end
                end
                LSL_RX_STOP: begin
                    if (s.rx_ovs == OVS_LAST) begin
                        if (rx_lvl) begin
                            push          = 1'b1;
                            push_ent.data = rx_char;
                            push_ent.pe   = rx_perr;
                            next_s.rx_st  = LSL_RX_IDLE;
                        end else if (rx_char == 8'h00 && !s.rx_par) begin
                            // all-zero frame: wait to see if the low outlasts a char
                            next_s.rx_st = LSL_RX_BREAK;
                        end else begin
                            push            = 1'b1;
                            push_ent.data   = rx_char;
                            push_ent.pe     = rx_perr;
                            push_ent.fe     = 1'b1;
                            next_s.rx_ovs   = 4'h0;
                            next_s.rx_bit   = 3'h0;
                            next_s.rx_shift = 8'h00;
                            next_s.rx_st    = LSL_RX_DATA;
                        end
                    end
                end
                LSL_RX_BREAK: begin
                    if (rx_lvl) begin
                        push          = 1'b1;
                        push_ent.pe   = rx_perr;
                        push_ent.fe   = 1'b1;
                        next_s.rx_st  = LSL_RX_IDLE;
                    end else if (s.low_cnt > char_ticks) begin
                        push          = 1'b1;
                        push_ent.brk  = 1'b1;
                        push_ent.fe   = 1'b1;
                        push_ent.pe   = 1'b1;
                        next_s.rx_st  = LSL_RX_WAITHI;
                    end
                end
                LSL_RX_WAITHI: begin
                    // no further chars however long the break lasts
                    if (rx_lvl) begin
                        next_s.rx_st = LSL_RX_IDLE;
                    end
                end
                default: begin
                    next_s.rx_st = LSL_RX_IDLE;
                end
            endcase
        end

        // -----------------------------------------------------------
        // receive buffer / fifo
        // -----------------------------------------------------------
        for (int i = 1; i < FIFO_DEPTH; i++) begin
            idx = s.rx_rd + 4'(i);
            if (5'(i) < s.rx_cnt) begin
                err_behind = err_behind | (|s.rx_mem[idx][10:8]);
            end
        end

        if (i_bus.rd && i_bus.addr == RX_TX_DATA_ADDR && s.rx_cnt != 5'h00) begin
            next_s.rx_rd  = s.rx_rd + 4'h1;
            next_s.rx_cnt = s.rx_cnt - 5'h01;
            head_changed  = 1'b1;
        end

        if (push) begin
            if (next_s.rx_cnt == rx_cap) begin
                next_s.oe = 1'b1;
                if (!fifo_en) begin
                    next_s.rx_mem[next_s.rx_rd] = push_ent;
                    head_changed                = 1'b1;
                    rx_write                    = 1'b1;
                end
            end else begin
                next_s.rx_mem[next_s.rx_rd + next_s.rx_cnt[3:0]] = push_ent;
                head_changed  = head_changed | (next_s.rx_cnt == 5'h00);
                next_s.rx_cnt = next_s.rx_cnt + 5'h01;
                rx_write      = 1'b1;
            end
        end

        // -----------------------------------------------------------
        // sticky line flags: read clears first, new events win
        // -----------------------------------------------------------
        if (lsr_rd) begin
            next_s.oe = 1'b0;
            next_s.pe = 1'b0;
            next_s.fe = 1'b0;
            next_s.brk = 1'b0;
            if (!err_behind) begin
                next_s.rfe = 1'b0;
            end
        end
        if (push && next_s.rx_cnt == rx_cap && s.rx_cnt == rx_cap) begin
            next_s.oe = 1'b1;
        end
        if (head_changed && next_s.rx_cnt != 5'h00) begin
            // flags surface only as their char reaches the head
            next_s.brk = next_s.brk | next_s.rx_mem[next_s.rx_rd].brk;
            next_s.fe = next_s.fe | next_s.rx_mem[next_s.rx_rd].fe;
            next_s.pe = next_s.pe | next_s.rx_mem[next_s.rx_rd].pe;
        end
        if (rx_write && fifo_en && (|push_ent[10:8])) begin
            next_s.rfe = 1'b1;
        end

        // -----------------------------------------------------------
        // transmitter
        // -----------------------------------------------------------
        if (s.tx_st == LSL_TX_IDLE && s.tx_cnt != 5'h00) begin
            tx_pop  = 1'b1;
            tx_data = s.tx_mem[s.tx_rd] & ~(8'hFF << nbits);
            tx_par  = (^tx_data) ^ ~even_par;
            next_s.tx_shift = '1;
            next_s.tx_shift[0] = 1'b0;
            for (int i = 0; i < 8; i++) begin
                if (4'(i) < nbits) begin
                    next_s.tx_shift[i + 1] = tx_data[i];
                end
            end
            if (parity_enable_bit) begin
                next_s.tx_shift[nbits + 4'h1] = tx_par;
            end
            next_s.tx_left = 4'h2 + nbits + {3'h0, parity_enable_bit};
            next_s.tx_ovs  = 4'h0;
            next_s.tx_st   = LSL_TX_SHIFT;
            next_s.tx_rd   = s.tx_rd + 4'h1;
            next_s.tx_cnt  = s.tx_cnt - 5'h01;
        end else if (s.tx_st == LSL_TX_SHIFT && tick) begin
            next_s.tx_ovs = s.tx_ovs + 4'h1;
            if (s.tx_ovs == OVS_LAST) begin
                next_s.tx_shift = {1'b1, s.tx_shift[11:1]};
                next_s.tx_left  = s.tx_left - 4'h1;
                if (s.tx_left == 4'h1) begin
                    next_s.tx_st = LSL_TX_IDLE;
                end
            end
        end

        if (tx_write) begin
            if (!fifo_en) begin
                // single holding register: a second write overwrites
                next_s.tx_mem[next_s.tx_rd] = i_bus.wdata[7:0];
                next_s.tx_cnt               = 5'h01;
            end else if (next_s.tx_cnt != FIFO_FULL) begin
                next_s.tx_mem[next_s.tx_rd + next_s.tx_cnt[3:0]] = i_bus.wdata[7:0];
                next_s.tx_cnt = next_s.tx_cnt + 5'h01;
            end
        end

        // -----------------------------------------------------------
        // status word
        // -----------------------------------------------------------
        lsr           = 16'h0000;
        lsr[LSR_DR]   = s.rx_cnt != 5'h00;
        lsr[LSR_OE]   = s.oe;
        lsr[LSR_PE]   = s.pe;
        lsr[LSR_FE]   = s.fe;
        lsr[LSR_BRK]  = s.brk;
        lsr[LSR_THRE] = thre_fifo ? (s.tx_cnt == FIFO_FULL)
                                  : (s.tx_cnt == 5'h00);
        lsr[LSR_TEMT] = (s.tx_cnt == 5'h00) && (s.tx_st == LSL_TX_IDLE);
        lsr[LSR_RFE]  = s.rfe & fifo_en;

        // -----------------------------------------------------------
        // register writes and interrupts
        // -----------------------------------------------------------
        if (i_bus.wr) begin
            unique case (i_bus.addr)
                LINE_CFG_ADDR:   next_s.cfg      = i_bus.wdata;
                INT_STATUS_ADDR: next_s.int_st   = s.int_st & ~i_bus.wdata[INT_W-1:0];
                INT_MASK_ADDR:   next_s.int_mask = i_bus.wdata[INT_W-1:0];
                default: begin
                end
            endcase
        end
        if (rx_write) begin
            next_s.int_st[INT_RX] = 1'b1;
        end
        if ((next_s.oe & ~s.oe) | (next_s.pe & ~s.pe) | (next_s.fe & ~s.fe)
                | (next_s.brk & ~s.brk)) begin
            next_s.int_st[INT_ERR] = 1'b1;
        end
        if (thre_fifo) begin
            if (next_s.tx_cnt <= thre_level) begin
                next_s.int_st[INT_THRE] = 1'b1;
            end
        end else if (tx_pop && next_s.tx_cnt == 5'h00) begin
            next_s.int_st[INT_THRE] = 1'b1;
        end
        next_s.irq = |(next_s.int_st & next_s.int_mask);

        // -----------------------------------------------------------
        // read data, one cycle after the strobe
        // -----------------------------------------------------------
        next_s.rdata = 16'h0000;
        if (i_bus.rd) begin
            unique case (i_bus.addr)
                RX_TX_DATA_ADDR:  next_s.rdata = {8'h00, s.rx_mem[s.rx_rd].data};
                LINE_STATUS_ADDR: next_s.rdata = lsr;
                LINE_CFG_ADDR:    next_s.rdata = s.cfg;
                INT_STATUS_ADDR:  next_s.rdata = {13'h0000, s.int_st};
                INT_MASK_ADDR:    next_s.rdata = {13'h0000, s.int_mask};
                default:          next_s.rdata = 16'h0000;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            s          <= '0;
            s.rx_s1    <= 1'b1;
            s.rx_s2    <= 1'b1;
            s.ir_s1    <= 1'b1;
            s.ir_s2    <= 1'b1;
            s.tx_shift <= '1;
            s.cfg      <= CFG_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign o_rdata     = s.rdata;
    assign o_tx_serial = s.tx_shift[0];
    assign o_irq       = s.irq;

endmodule // lsl_line_status

// File: bench/lsl_far_dev.sv
`timescale 1ns/1ps
module lsl_far_dev (
    input  wire logic i_mclk,
    input  wire logic i_tick,
    input  wire logic i_tx,
    output logic      o_line
);
    initial o_line = 1'b1;
    task automatic ticks(input int n);
        repeat (n) @(posedge i_mclk iff i_tick);
    endtask
    // stop level and length are the caller's, so bad stops and breaks reuse it
    task automatic send(input int d, nb, p, input logic s);
        int m = nb + int'(p >= 0);
        int f = d | (int'(p[0]) << nb);
        for (int i = -1; i <= m; i++) begin
            o_line <= (i < 0) ? 1'b0 : (i < m) ? f[i] : s;
            ticks(16);
        end
        if (!s) o_line <= 1'b1;
    endtask
    task automatic recv(output logic [7:0] d);
        for (int n = 0; n < 4000 && i_tx; n++) @(posedge i_mclk);
        ticks(8);
        for (int i = 0; i < 8; i++) begin
            ticks(16);
            d[i] = i_tx;
        end
    endtask
endmodule // lsl_far_dev

// File: bench/lsl_chk_asserts.sv
`timescale 1ns/1ps
module lsl_chk_asserts
    import lsl_pkg::*;
(
    input wire logic              i_mclk,
    input wire logic              i_reset_n,
    input wire lsl_bus_req_t      i_bus,
    input wire logic [DATA_W-1:0] o_rdata,
    input wire logic              o_tx_serial,
    input wire logic              o_irq
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    wire st  = i_bus.rd && i_bus.addr == LINE_STATUS_ADDR;
    wire hit = i_bus.addr inside {RX_TX_DATA_ADDR, LINE_STATUS_ADDR, LINE_CFG_ADDR,
                                  INT_STATUS_ADDR, INT_MASK_ADDR};
    a_rdata_idle: assert property (!i_bus.rd |=> o_rdata == '0) else $error("stray read data");
    a_unmapped_zero: assert property (i_bus.rd && !hit |=> o_rdata == '0) else $error("bad unmapped");
    a_status_upper: assert property (st |=> o_rdata[15:8] == 8'h00) else $error("upper bits set");
    a_break_all: assert property (
        st |=> !o_rdata[LSR_BRK] || (o_rdata[LSR_FE] && o_rdata[LSR_PE])) else $error("lone break");
    a_reset_out: assert property ($rose(i_reset_n) |-> o_tx_serial && !o_irq) else $error("reset out");
    a_mask_irq: assert property (i_bus.wr && i_bus.addr == INT_MASK_ADDR &&
        i_bus.wdata[2:0] == 3'h0 |=> ##1 !o_irq) else $error("masked irq high");
    // a bit lasts sixteen ticks; both checks ask for at least eight cycles at one level
    a_tx_low_hold: assert property ($fell(o_tx_serial) |-> !o_tx_serial[*8]) else $error("short low");
    a_tx_high_hold: assert property ($rose(o_tx_serial) |-> o_tx_serial[*8]) else $error("short high");
    c_break: cover property (st ##1 o_rdata[LSR_BRK]);
    c_irq: cover property ($rose(o_irq));
    c_tx: cover property ($fell(o_tx_serial));
endmodule // lsl_chk_asserts
bind lsl_line_status lsl_chk_asserts u_chk (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .i_bus(i_bus), .o_rdata(o_rdata), .o_tx_serial(o_tx_serial), .o_irq(o_irq));

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import lsl_pkg::*;
    typedef struct {logic [15:0] c; logic [7:0] d; int p; logic [15:0] s;} lsl_row_t;
    lsl_row_t     rows[4] = '{'{16'h0000, 8'h15, -1, 16'h0061},
        '{16'h0062, 8'h01, 0, 16'h0061}, '{16'h0062, 8'h01, 1, 16'h0065},
        '{16'h0066, 8'h03, 1, 16'h0065}};
    logic         i_mclk = 1'b0;
    logic         rst_n = 1'b0;
    logic         tick = 1'b0;
    lsl_bus_req_t bus = '0;
    logic [15:0]  rdata;
    logic         rx, tx, irq, ir = 1'b1;
    logic [7:0]   got;
    int           n_errors = 0;
    int           samples_checked = 0;
    always #10 i_mclk = ~i_mclk;
    always @(posedge i_mclk) tick <= ~tick;
    lsl_line_status i_dut (.i_mclk(i_mclk), .i_reset_n(rst_n), .i_bus(bus), .o_rdata(rdata),
        .i_sample_tick(tick), .i_rx_serial(rx), .i_ir_serial(ir), .o_tx_serial(tx),
        .o_irq(irq));
    lsl_far_dev u_far (.i_mclk(i_mclk), .i_tick(tick), .i_tx(tx), .o_line(rx));
    task automatic finish_test;
        if (n_errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge i_mclk) bus <= '{a, d, 1'b1, 1'b0};
        @(posedge i_mclk) bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [15:0] e, input string nm);
        @(posedge i_mclk) bus <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge i_mclk) bus.rd <= 1'b0;
        #1 chk(nm, rdata, e);
    endtask
    task automatic st(input logic [15:0] e);
        rd(LINE_STATUS_ADDR, e, "line_status");
    endtask
    task automatic dt(input logic [7:0] e);
        rd(RX_TX_DATA_ADDR, {8'h00, e}, "rx_data");
    endtask
    // the character lands half a stop bit before the frame ends
    task automatic gap;
        repeat (8) @(posedge i_mclk);
    endtask
    initial begin
        repeat (4) @(posedge i_mclk);
        rst_n <= 1'b1;
        st(16'h0060);
        rd(32'h5000_1030, 16'h0000, "unmapped");
        for (int k = 0; k < 4; k++) begin
            wr(LINE_CFG_ADDR, rows[k].c);
            u_far.send(rows[k].d, 5 + rows[k].c[6:5], rows[k].p, 1'b1);
            gap();
            st(rows[k].s);
            dt(rows[k].d);
        end
        wr(LINE_CFG_ADDR, 16'h0060);
        u_far.send(8'h12, 8, -1, 1'b1);
        u_far.send(8'h34, 8, -1, 1'b1);
        gap();
        st(16'h0063);
        dt(8'h34);
        u_far.send(8'h3C, 8, -1, 1'b0);
        gap();
        st(16'h0069);
        dt(8'h3C);
        u_far.ticks(144);
        gap();
        dt(8'hFF);
        u_far.send(0, 29, -1, 1'b0);
        gap();
        st(16'h007D);
        dt(8'h00);
        st(16'h0060);
        wr(LINE_CFG_ADDR, 16'h0068);
        repeat (14) begin
            ir <= 1'b0;
            u_far.ticks(3);
            ir <= 1'b1;
            u_far.ticks(13);
        end
        gap();
        st(16'h007D);
        dt(8'h00);
        wr(LINE_CFG_ADDR, 16'h0063);
        u_far.send(8'h11, 8, 1, 1'b1);
        u_far.send(8'h22, 8, 0, 1'b1);
        gap();
        st(16'h00E1);
        dt(8'h11);
        st(16'h00E5);
        st(16'h0061);
        dt(8'h22);
        wr(LINE_CFG_ADDR, 16'h0061);
        for (int k = 0; k < 17; k++) u_far.send(k, 8, -1, 1'b1);
        gap();
        st(16'h0063);
        for (int k = 0; k < 16; k++) dt(8'(k));
        st(16'h0060);
        wr(INT_STATUS_ADDR, 16'h0007);
        wr(INT_MASK_ADDR, 16'h0004);
        wr(RX_TX_DATA_ADDR, 16'h005A);
        fork
            u_far.recv(got);
            begin
                gap();
                st(16'h0020);
                chk("irq", 16'(irq), 16'h0001);
                wr(INT_MASK_ADDR, 16'h0000);
                repeat (2) @(negedge i_mclk);
                chk("irq", 16'(irq), 16'h0000);
            end
        join
        chk("tx_data", {8'h00, got}, 16'h005A);
        u_far.ticks(32);
        st(16'h0060);
        wr(INT_STATUS_ADDR, 16'h0004);
        wr(INT_MASK_ADDR, 16'h0004);
        repeat (2) @(negedge i_mclk);
        chk("irq", 16'(irq), 16'h0000);
        wr(LINE_CFG_ADDR, 16'h0071);
        st(16'h0040);
        chk("irq", 16'(irq), 16'h0001);
        for (int k = 0; k < 17; k++) wr(RX_TX_DATA_ADDR, 16'h0000);
        wr(INT_STATUS_ADDR, 16'h0004);
        st(16'h0020);
        chk("irq", 16'(irq), 16'h0000);
        finish_test();
    end
    initial begin
        repeat (100000) @(posedge i_mclk);
        n_errors++;
        finish_test();
    end
endmodule // testbench
